// ==== hdl/tmit_core.sv ====
// Interrupt, interval timer, CPU clock select and blink divider of the terminal processor
//
// Behaviour
// - Eight-bit up timer sets overflow flag and internal request on FF to 00.
// - Timer advances every 32 CPU cycles; start-timer clears the prescaler.
// - After overflow the timer keeps counting, flagging every later wrap.
// - Only the two timer-flag jumps clear the overflow flag.
// - Separate external and internal master enables set and cleared by instructions.
// - Finish instruction, two push cycles, then load vector 3 or 7.
// - During service all further interrupts wait until return-restore-status.
// - Simultaneous external and internal requests: external taken first.
// - External pin is level sampled; low level while sampled requests.
// - Software can read the external pin level directly.
// - Mask register from accumulator gates each internal flag, one enables.
// - Bit 0 sets at end of the chosen row unless beyond length; read clears.
// - Bit 1 sets at each unblanked row end; home pointer write clears.
// - Bit 2 sets when transmit buffer moves to shift register; buffer write clears.
// - Bit 3 sets when both transmit stages are empty; buffer load clears.
// - Bit 4 sets on receive buffer load; receive buffer read clears.
// - Bit 5 sets on sampled falling pen edge; flag read clears.
// - Bit 6 sets on timer wrap; flag read clears.
// - Bit 7 sets on each real-time clock tick; flag read clears.
// - CPU clock is crystal undivided or divided by 1.5, per control bit 0.
// - Vsync divided by 5-bit divisor gives cursor blink; halved gives others.
// - Return-restore-status restores five saved status bits; plain return only two.
`timescale 1ns/1ps
`include "tmit_defines.svh"

module tmit_core #(
    parameter int FLAG_W = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire tmit_pkg::tmit_cmd_t cmd,
    input wire tmit_pkg::tmit_evt_t evt,
    input wire logic [7:0] acc_in,
    input wire logic [4:0] stack_status_in,
    input wire logic [4:0] vert_irq_row,
    input wire logic [4:0] vert_length,
    input wire logic [4:0] blink_divisor,
    input wire logic sys_ctrl_clkdiv,
    input wire logic external_irq_n,
    input wire logic pen_strobe_n,
    output logic cpu_clk_en,
    output logic [7:0] flags_rd,
    output logic [7:0] timer_rd,
    output logic timer_flag,
    output logic ext_pin_level,
    output logic irq_accept,
    output logic push_active,
    output logic [12:0] vector,
    output logic vector_load,
    output logic in_service,
    output logic [4:0] restore_bits,
    output logic restore_strobe,
    output logic restore_all,
    output logic cursor_blink,
    output logic char_blink
);

    tmit_pkg::tmit_regs_t r_ff;
    tmit_pkg::tmit_regs_t nxt_r;
    logic cpu_tick;
    logic wrap;
    logic ext_req;
    logic int_req;
    logic [FLAG_W-1:0] set_v;
    logic [FLAG_W-1:0] clr_v;
    logic blink_tick;
    // Per-bit flag and mask product; any one of these raises the internal class
    logic [FLAG_W-1:0] pend_v;

    // ------------------------------------------------------------
    // CPU clock enable
    // ------------------------------------------------------------
    // The CPU never gets a clock of its own: every register runs on the crystal edge
    // and the CPU-side work is qualified by cpu_tick instead.
    // The phase counter runs 0, 1, 2 while dividing; phase 2 is the swallowed edge.
    // A change of the select bit acts at once, the phase restarting from 0.
    // Divide by 1.5 passes two crystal edges out of three; no second clock domain needed
    assign cpu_tick = sys_ctrl_clkdiv ? (r_ff.cpu_phase != 2'd2) : 1'b1;
    assign cpu_clk_en = cpu_tick;

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    // Timer wrap: last prescaler step of a CPU tick while the count stands at all ones
    assign wrap = cpu_tick && r_ff.run && (r_ff.presc == `TMIT_PRESCALE_DIV) && (r_ff.count == 8'hff);

    // External class needs only its pin low and its master enable; the pin is looked
    // at only on an instruction boundary in idle, so a source must hold it low until it is accepted
    assign ext_req = !external_irq_n && r_ff.ext_en;

    // Mask gating one bit at a time; a zero mask bit keeps the flag from requesting,
    // but the flag still sets so polling software can see it
    for (genvar gi = 0; gi < FLAG_W; gi++) begin : g_gate
        assign pend_v[gi] = r_ff.flags[gi] && r_ff.mask[gi];
    end
    assign int_req = (|pend_v) && r_ff.int_en;

    // Blink tick on the vsync that completes a divisor count; a divisor of zero
    // is taken as one so the blink clocks and the real-time flag never stop
    assign blink_tick = evt.vsync && ((r_ff.blink_cnt == blink_divisor - 5'd1) || (blink_divisor == 5'd0));

    // Per-bit set and clear sources of the internal flag register
    always_comb begin
        set_v = '0;
        clr_v = '0;

        // Bit 0: end of the selected row; a row number beyond the frame never matches
        set_v[`TMIT_BIT_VERT] = evt.row_end && (r_ff.row_cnt == vert_irq_row) && (vert_irq_row <= vert_length);
        clr_v[`TMIT_BIT_VERT] = cmd.read_flags;

        // Bit 1: every row end that is not blanked; a home pointer write clears it
        set_v[`TMIT_BIT_ROW] = evt.row_end && !evt.row_blanked;
        clr_v[`TMIT_BIT_ROW] = evt.home_write;

        // Bit 2: holding buffer handed its character to the shift register
        set_v[`TMIT_BIT_TXBUF] = evt.tx_buf_to_shift;
        clr_v[`TMIT_BIT_TXBUF] = evt.tx_buf_write;

        // Bit 3: shift register empty while the buffer is empty too
        set_v[`TMIT_BIT_TXEMPTY] = evt.tx_shift_empty && r_ff.flags[`TMIT_BIT_TXBUF];
        clr_v[`TMIT_BIT_TXEMPTY] = evt.tx_buf_write;

        // Bit 4: receive buffer loaded from the shift register
        set_v[`TMIT_BIT_RXFULL] = evt.rx_buf_load;
        clr_v[`TMIT_BIT_RXFULL] = evt.rx_buf_read;

        // Bit 5: falling pen edge, seen only on CPU ticks so a short glitch is missed
        set_v[`TMIT_BIT_PEN] = cpu_tick && r_ff.pen_prev && !pen_strobe_n;
        clr_v[`TMIT_BIT_PEN] = cmd.read_flags;

        // Bit 6: timer wrap, the same event that sets the overflow flag
        set_v[`TMIT_BIT_TIMER] = wrap;
        clr_v[`TMIT_BIT_TIMER] = cmd.read_flags;

        // Bit 7: real-time tick, at half the cursor blink rate
        set_v[`TMIT_BIT_RTC] = blink_tick && r_ff.cursor_blink;
        clr_v[`TMIT_BIT_RTC] = cmd.read_flags;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        nxt_r.vector_load = 1'b0;
        // One-cycle pulses fall back unless set again below
        nxt_r.restore_strobe = 1'b0;
        nxt_r.restore_full = 1'b0;

        // Phase advances on ticks and restarts on the swallowed edge
        if (cpu_tick) begin
            nxt_r.cpu_phase = (sys_ctrl_clkdiv && r_ff.cpu_phase != 2'd2) ? r_ff.cpu_phase + 2'd1 : 2'd0;
        end else begin
            nxt_r.cpu_phase = 2'd0;
        end

        // Master enables; enable wins if software strobes both at once,
        // which the core never does
        // Master enables
        if (cmd.ext_enable) begin
            nxt_r.ext_en = 1'b1;
        end else if (cmd.ext_disable) begin
            nxt_r.ext_en = 1'b0;
        end
        if (cmd.int_enable) begin
            nxt_r.int_en = 1'b1;
        end else if (cmd.int_disable) begin
            nxt_r.int_en = 1'b0;
        end

        // Mask is written whole from the accumulator; there is no read path
        if (cmd.write_mask) begin
            nxt_r.mask = acc_in;
        end

        // Timer: stop, start and load act on the instruction cycle
        // Start clears the prescaler so the first count is a full one;
        // stop leaves both prescaler and count where they are.
        // Counting has no reload: after a wrap it simply goes on from zero
        if (cmd.stop_timer) begin
            nxt_r.run = 1'b0;
        end
        if (cmd.start_timer) begin
            nxt_r.run = 1'b1;
            nxt_r.presc = 5'd0;
        end else if (cpu_tick && r_ff.run) begin
            nxt_r.presc = r_ff.presc + 5'd1;
            if (r_ff.presc == `TMIT_PRESCALE_DIV) begin
                nxt_r.count = r_ff.count + 8'd1;
            end
        end
        // Load wins over a count step in the same cycle
        if (cmd.load_timer) begin
            nxt_r.count = acc_in;
        end

        // Set wins over the jump clear so a wrap in that cycle is kept
        if (wrap) begin
            nxt_r.tflag = 1'b1;
        end else if (cmd.jump_if_timer_flag || cmd.jump_if_no_timer_flag) begin
            nxt_r.tflag = 1'b0;
        end

        // Internal flags, set beats clear
        nxt_r.flags = (r_ff.flags & ~clr_v) | set_v;
        if (cpu_tick) begin
            nxt_r.pen_prev = pen_strobe_n;
        end

        // Row counter for the vertical row match
        if (evt.vsync) begin
            nxt_r.row_cnt = 5'd0;
        end else if (evt.row_end) begin
            nxt_r.row_cnt = r_ff.row_cnt + 5'd1;
        end

        // Blink divider; a divisor of zero is treated as one
        // Char blink toggles on every second cursor toggle, giving the halving
        if (evt.vsync) begin
            if (blink_tick || blink_divisor == 5'd0) begin
                nxt_r.blink_cnt = 5'd0;
                nxt_r.cursor_blink = !r_ff.cursor_blink;
                if (r_ff.cursor_blink) begin
                    nxt_r.char_blink = !r_ff.char_blink;
                end
            end else begin
                nxt_r.blink_cnt = r_ff.blink_cnt + 5'd1;
            end
        end

        // Interrupt entry and lockout
        // Requests are only looked at on an instruction boundary in idle; from
        // acceptance to the restoring return everything else waits, so a long
        // handler delays both classes
        case (r_ff.state)
            tmit_pkg::TMIT_IDLE: begin
                if (cmd.instr_done && (ext_req || int_req)) begin
                    nxt_r.state = tmit_pkg::TMIT_PUSH;
                    nxt_r.ext_sel = ext_req;
                    nxt_r.push_cnt = 2'd0;
                    nxt_r.push_active = 1'b1;
                end
            end
            tmit_pkg::TMIT_PUSH: begin
                if (cpu_tick) begin
                    if (r_ff.push_cnt == `TMIT_ENTRY_CYCLES - 2'd1) begin
                        nxt_r.state = tmit_pkg::TMIT_SERVICE;
                        nxt_r.push_active = 1'b0;
                        nxt_r.vector = r_ff.ext_sel ? `TMIT_VEC_EXT : `TMIT_VEC_INT;
                        nxt_r.vector_load = 1'b1;
                    end else begin
                        nxt_r.push_cnt = r_ff.push_cnt + 2'd1;
                    end
                end
            end
            tmit_pkg::TMIT_SERVICE: begin
                if (cmd.return_restore_status) begin
                    nxt_r.state = tmit_pkg::TMIT_IDLE;
                end
            end
            default: begin
                nxt_r.state = tmit_pkg::TMIT_IDLE;
            end
        endcase
        // Status restore on either return
        if (cmd.return_restore_status || cmd.plain_return) begin
            nxt_r.restore_bits = stack_status_in;
            nxt_r.restore_strobe = 1'b1;
            nxt_r.restore_full = cmd.return_restore_status;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // Everything clear and stopped; pen history starts high, the idle pin level,
            // so no false pen edge follows reset
            r_ff <= '{
                state: tmit_pkg::TMIT_IDLE,
                push_cnt: 2'd0,
                ext_sel: 1'b0,
                ext_en: 1'b0,
                int_en: 1'b0,
                run: 1'b0,
                presc: 5'd0,
                count: 8'h00,
                tflag: 1'b0,
                flags: `TMIT_FLAGS_RESET,
                mask: `TMIT_MASK_RESET,
                pen_prev: 1'b1,
                blink_cnt: 5'd0,
                cursor_blink: 1'b0,
                char_blink: 1'b0,
                row_cnt: 5'd0,
                cpu_phase: 2'd0,
                vector: 13'h0000,
                vector_load: 1'b0,
                push_active: 1'b0,
                restore_bits: 5'd0,
                restore_strobe: 1'b0,
                restore_full: 1'b0
            };
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign flags_rd = r_ff.flags;
    assign timer_rd = r_ff.count;
    assign timer_flag = r_ff.tflag;
    assign ext_pin_level = external_irq_n;
    assign irq_accept = (r_ff.state == tmit_pkg::TMIT_IDLE) && cmd.instr_done && (ext_req || int_req);
    assign push_active = r_ff.push_active;
    assign vector = r_ff.vector;
    assign vector_load = r_ff.vector_load;
    assign in_service = (r_ff.state != tmit_pkg::TMIT_IDLE);
    assign restore_bits = r_ff.restore_bits;
    assign restore_strobe = r_ff.restore_strobe;
    // Plain return restores only the two bank bits; the core reads this to pick.
    // The kind of return is registered, as a plain return may come outside service
    assign restore_all = r_ff.restore_strobe && r_ff.restore_full;
    assign cursor_blink = r_ff.cursor_blink;
    assign char_blink = r_ff.char_blink;

endmodule : tmit_core

// ==== hdl/tmit_defines.svh ====
// Offsets, field positions, reset values and timing counts of the interrupt and timer block
`ifndef TMIT_DEFINES_SVH
`define TMIT_DEFINES_SVH
`define TMIT_PRESCALE_DIV 5'd31
`define TMIT_ENTRY_CYCLES 2'd2
`define TMIT_VEC_EXT 13'h0003
`define TMIT_VEC_INT 13'h0007
`define TMIT_BIT_VERT 0
`define TMIT_BIT_ROW 1
`define TMIT_BIT_TXBUF 2
`define TMIT_BIT_TXEMPTY 3
`define TMIT_BIT_RXFULL 4
`define TMIT_BIT_PEN 5
`define TMIT_BIT_TIMER 6
`define TMIT_BIT_RTC 7
`define TMIT_SCR_CLKDIV_BIT 0
`define TMIT_MASK_RESET 8'h00
`define TMIT_FLAGS_RESET 8'h00
`endif

// ==== hdl/tmit_pkg.sv ====
// Types shared by the interrupt and timer block
package tmit_pkg;
    typedef enum logic [1:0] {
        TMIT_IDLE,
        TMIT_PUSH,
        TMIT_SERVICE
    } tmit_state_t;

    // Instruction strobes from the processor core, one cycle each
    typedef struct packed {
        logic start_timer;
        logic stop_timer;
        logic load_timer;
        logic jump_if_timer_flag;
        logic jump_if_no_timer_flag;
        logic ext_enable;
        logic ext_disable;
        logic int_enable;
        logic int_disable;
        logic write_mask;
        logic read_flags;
        logic return_restore_status;
        logic plain_return;
        logic instr_done;
    } tmit_cmd_t;

    // Events from the video and serial sections, one cycle each
    typedef struct packed {
        logic row_end;
        logic row_blanked;
        logic home_write;
        logic tx_buf_to_shift;
        logic tx_shift_empty;
        logic tx_buf_write;
        logic rx_buf_load;
        logic rx_buf_read;
        logic vsync;
    } tmit_evt_t;

    typedef struct packed {
        tmit_state_t state;
        logic [1:0] push_cnt;
        logic ext_sel;
        logic ext_en;
        logic int_en;
        logic run;
        logic [4:0] presc;
        logic [7:0] count;
        logic tflag;
        logic [7:0] flags;
        logic [7:0] mask;
        logic pen_prev;
        logic [4:0] blink_cnt;
        logic cursor_blink;
        logic char_blink;
        logic [4:0] row_cnt;
        logic [1:0] cpu_phase;
        logic [12:0] vector;
        logic vector_load;
        logic push_active;
        logic [4:0] restore_bits;
        logic restore_strobe;
        logic restore_full;
    } tmit_regs_t;
endpackage : tmit_pkg

// ==== testbench/tmit_monitor.sv ====
// Port-level assertions for the interrupt and timer core
`timescale 1ns/1ps
module tmit_monitor (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire tmit_pkg::tmit_cmd_t cmd,
    input wire logic sys_ctrl_clkdiv,
    input wire logic external_irq_n,
    input wire logic cpu_clk_en,
    input wire logic [7:0] flags_rd,
    input wire logic [7:0] timer_rd,
    input wire logic timer_flag,
    input wire logic ext_pin_level,
    input wire logic irq_accept,
    input wire logic push_active,
    input wire logic vector_load,
    input wire logic in_service
);
    // ----------------------------------------
    // Assertions, all in the crystal domain
    // ----------------------------------------
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_pin_level: assert property (ext_pin_level == external_irq_n) else $error("pin level differs");
    a_flag_hold: assert property (
        timer_flag && !cmd.jump_if_timer_flag && !cmd.jump_if_no_timer_flag |=> timer_flag) else $error("flag lost");
    a_flag_wrap: assert property (
        $rose(timer_flag) |-> timer_rd == 8'h00 && $past(timer_rd) == 8'hff) else $error("flag without wrap");
    a_bit6_wrap: assert property ($rose(flags_rd[6]) |-> timer_rd == 8'h00) else $error("bit 6 without wrap");
    a_lockout: assert property ($past(in_service) && in_service |-> !irq_accept) else $error("accept in service");
    a_accept_bound: assert property (irq_accept |-> cmd.instr_done) else $error("accept mid instruction");
    a_entry_seq: assert property (
        irq_accept && !sys_ctrl_clkdiv |=> push_active [*2] ##1 vector_load) else $error("entry sequence");
    a_cpu_full: assert property (!sys_ctrl_clkdiv [*2] |-> cpu_clk_en) else $error("undivided clock gap");
    a_cpu_div: assert property (
        sys_ctrl_clkdiv [*4] |-> $countones({cpu_clk_en, $past(cpu_clk_en), $past(cpu_clk_en, 2)}) == 2)
        else $error("divide by 1.5 ratio");
    a_service_end: assert property (
        $fell(in_service) |-> cmd.return_restore_status || $past(cmd.return_restore_status))
        else $error("service ended without return");
endmodule : tmit_monitor

// ==== testbench/tmit_cpu_model.sv ====
// Behavioural processor core: instruction boundaries and end of interrupt service
`timescale 1ns/1ps
module tmit_cpu_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic irq_accept,
    input wire logic vector_load,
    input wire logic [7:0] svc_len,
    output logic instr_done,
    output logic ret_strobe
);
    logic pushing_ff;
    logic [7:0] left_ff;
    // No boundary during the push cycles; the handler runs svc_len cycles, so a slow one widens the lockout
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            instr_done <= 1'b0;
            ret_strobe <= 1'b0;
            pushing_ff <= 1'b0;
            left_ff <= 8'h00;
        end else begin
            instr_done <= !(irq_accept || pushing_ff);
            pushing_ff <= irq_accept || (pushing_ff && !vector_load);
            left_ff <= vector_load ? svc_len : ((left_ff != 8'h00) ? left_ff - 8'h01 : 8'h00);
            ret_strobe <= (left_ff == 8'h01);
        end
    end
endmodule : tmit_cpu_model

// ==== testbench/tb_terminal_cpu_interrupt_timer.sv ====
// Self-checking bench for the interrupt, timer and clock-select core
`timescale 1ns/1ps
module tb_terminal_cpu_interrupt_timer;
    // ----------------------------------------
    // Stimulus, reference queue and design
    // ----------------------------------------
    localparam int C_START = 22, C_STOP = 21, C_LOAD = 20, C_JTF = 19, C_EXTEN = 17, C_INTEN = 15;
    localparam int C_MASK = 13, C_READ = 12, E_TXSH = 5, E_TXWR = 3, E_RXLD = 2, E_RXRD = 1, E_VS = 0;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [22:0] drv = '0;
    logic [7:0] acc_in = 8'h00;
    logic [7:0] svc_len = 8'h08;
    logic [4:0] stat = 5'h00;
    logic clkdiv = 1'b0;
    logic ext_n = 1'b1;
    logic pen_n = 1'b1;
    logic cpu_done, cpu_ret, cpu_clk_en, timer_flag, ext_pin_level, irq_accept, push_active, vector_load, in_service;
    logic [7:0] flags_rd, timer_rd;
    logic cursor_blink, char_blink, restore_strobe, restore_all;
    logic exp_all = 1'b1;
    logic [4:0] restore_bits;
    logic [12:0] vector;
    logic [12:0] exp_vec[$];
    tmit_pkg::tmit_cmd_t cmd;
    tmit_pkg::tmit_evt_t evt;
    int failures = 0;
    int tests_run = 0;
    int n = 0;
    // Bench strobes merged with the core model's boundary and return strobes
    assign cmd = tmit_pkg::tmit_cmd_t'(drv[22:9] | {11'h000, cpu_ret, 1'b0, cpu_done});
    assign evt = tmit_pkg::tmit_evt_t'(drv[8:0]);
    tmit_core i_tmit_core (.sys_clk, .rstn, .cmd, .evt, .acc_in, .stack_status_in(stat), .vert_irq_row(5'h03),
        .vert_length(5'h18), .blink_divisor(5'h02), .sys_ctrl_clkdiv(clkdiv), .external_irq_n(ext_n),
        .pen_strobe_n(pen_n), .cpu_clk_en, .flags_rd, .timer_rd, .timer_flag, .ext_pin_level, .irq_accept,
        .push_active, .vector, .vector_load, .in_service, .restore_bits, .restore_strobe, .restore_all,
        .cursor_blink, .char_blink);
    tmit_cpu_model i_tmit_cpu_model (.sys_clk, .rstn, .irq_accept, .vector_load, .svc_len,
        .instr_done(cpu_done), .ret_strobe(cpu_ret));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One-cycle strobe, then an idle edge so no signal is driven twice in one step
    task automatic pulse(input int b);
        drv[b] <= 1'b1;
        @(posedge sys_clk);
        drv[b] <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse
    task automatic wait_chg();
        logic [7:0] t0;
        t0 = timer_rd;
        n = 0;
        while (timer_rd === t0 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_chg
    task automatic wait_vec();
        int k;
        k = 0;
        // Step past a load pulse still showing from the previous call
        @(posedge sys_clk);
        while (vector_load !== 1'b1 && k < 300) begin
            @(posedge sys_clk);
            k++;
        end
    endtask : wait_vec
    task automatic complete_run();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // Every vector load is compared with the next expected entry
    always @(posedge sys_clk) begin
        if (rstn && vector_load === 1'b1) begin
            chk(vector, (exp_vec.size() > 0) ? exp_vec.pop_front() : 13'h1fff);
        end
        if (rstn && restore_strobe === 1'b1) begin
            chk(13'(restore_bits), 13'(stat));
            chk(13'(restore_all), 13'(exp_all));
        end
    end
    initial begin
        #400000;
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(73));
        svc_len = 8'(8 + $urandom % 8);
        stat = 5'($urandom);
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        // Timer loaded near the top: prescale period, wrap, sticky flag
        acc_in <= 8'hfe;
        pulse(C_LOAD);
        pulse(C_START);
        wait_chg();
        wait_chg();
        chk(13'(n), 13'h0020);
        chk(13'(timer_rd), 13'h0000);
        chk(13'(timer_flag), 13'h0001);
        chk(13'(flags_rd[6]), 13'h0001);
        wait_chg();
        chk(13'(timer_rd), 13'h0001);
        chk(13'(timer_flag), 13'h0001);
        pulse(C_JTF);
        chk(13'(timer_flag), 13'h0000);
        pulse(C_STOP);
        // Masked flag stays quiet; external then beats a pending internal source
        exp_vec = {13'h0007, 13'h0003, 13'h0007};
        pulse(C_EXTEN);
        pulse(C_INTEN);
        repeat (10) @(posedge sys_clk);
        chk(13'(in_service), 13'h0000);
        acc_in <= 8'h50;
        pulse(C_MASK);
        wait_vec();
        pulse(C_READ);
        chk(13'(flags_rd[6]), 13'h0000);
        ext_n <= 1'b0;
        pulse(E_RXLD);
        chk(13'(flags_rd[4]), 13'h0001);
        wait_vec();
        ext_n <= 1'b1;
        wait_vec();
        pulse(E_RXRD);
        chk(13'(flags_rd[4]), 13'h0000);
        repeat (30) @(posedge sys_clk);
        // Masked sources still flag and clear
        pulse(E_TXSH);
        chk(13'(flags_rd[2]), 13'h0001);
        pulse(4);
        chk(13'(flags_rd[3]), 13'h0001);
        pulse(E_TXWR);
        chk(13'(flags_rd[2]), 13'h0000);
        chk(13'(flags_rd[3]), 13'h0000);
        pulse(4);
        chk(13'(flags_rd[3]), 13'h0000);
        pen_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(13'(flags_rd[5]), 13'h0001);
        pulse(C_READ);
        repeat (4) @(posedge sys_clk);
        chk(13'(flags_rd[5]), 13'h0000);
        pen_n <= 1'b1;
        // No video here, so the cell-width duty on software needs nothing
        clkdiv <= 1'b1;
        for (int i = 1; i <= 8; i++) begin
            pulse(E_VS);
            chk(13'(cursor_blink), 13'((i / 2) % 2));
            chk(13'(char_blink), 13'((i / 4) % 2));
        end
        chk(13'(flags_rd[7]), 13'h0001);
        clkdiv <= 1'b0;
        // Rows counted from the last vsync; row 3 is the chosen one
        for (int i = 0; i < 4; i++) begin
            pulse(8);
            chk(13'(flags_rd[0]), 13'(i == 3));
        end
        chk(13'(flags_rd[1]), 13'h0001);
        pulse(6);
        chk(13'(flags_rd[1]), 13'h0000);
        drv[8:7] <= 2'b11;
        @(posedge sys_clk);
        drv[8:7] <= 2'b00;
        @(posedge sys_clk);
        chk(13'(flags_rd[1]), 13'h0000);
        pulse(C_READ);
        chk(13'(flags_rd[0]), 13'h0000);
        chk(13'(flags_rd[7]), 13'h0000);
        // Plain return outside service restores only the bank bits
        exp_all = 1'b0;
        pulse(10);
        @(posedge sys_clk);
        exp_all = 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(13'(exp_vec.size()), 13'h0000);
        complete_run();
    end
endmodule : tb_terminal_cpu_interrupt_timer
bind tmit_core tmit_monitor i_tmit_monitor (.sys_clk, .rstn, .cmd, .sys_ctrl_clkdiv, .external_irq_n, .cpu_clk_en,
    .flags_rd, .timer_rd, .timer_flag, .ext_pin_level, .irq_accept, .push_active, .vector_load, .in_service);
